/* rfa_pkg.sv */
package rfa_pkg;

  // ************************************************************
  // Access attributes
  // ************************************************************
  typedef enum {
    ATTR_HARDWARE_INITIALISED_FIELD,
    ATTR_RO,
    ATTR_WO,
    ATTR_RW,
    ATTR_W1C,
    ATTR_W1S,
    ATTR_RWS,
    ATTR_STICKY_WRITE_ONE_CLEAR_FIELD,
    ATTR_RSVD
  } rfa_attr_t;

  // ************************************************************
  // Access port geometry
  // ************************************************************
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned NUM_WORDS = 10;

  // ************************************************************
  // Word indices
  // ************************************************************
  localparam logic [ADDR_W-1:0] IDX_STRUCT_PARAMS = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_HW_STATUS     = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_WRITE_ONCE    = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_CONTROL       = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_EVENT         = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_SET_ONLY      = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_STICKY_CTRL   = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_STICKY_EVENT  = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_RESERVED      = 4'h8;
  localparam logic [ADDR_W-1:0] IDX_COMMAND       = 4'h9;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int unsigned PORT_COUNT_LSB        = 0;
  localparam int unsigned PORT_COUNT_W          = 8;
  localparam int unsigned CONTROLLER_RESET_FLAG = 0;

  // ************************************************************
  // Per-word attribute, reset value and masks
  // ************************************************************
  localparam rfa_attr_t WORD_ATTR [0:NUM_WORDS-1] = '{
    ATTR_HARDWARE_INITIALISED_FIELD, ATTR_RO, ATTR_WO, ATTR_RW, ATTR_W1C,
    ATTR_W1S, ATTR_RWS, ATTR_STICKY_WRITE_ONE_CLEAR_FIELD, ATTR_RSVD, ATTR_RW
  };
  localparam logic [DATA_W-1:0] WORD_RESET [0:NUM_WORDS-1] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000
  };
  localparam logic [DATA_W-1:0] WORD_RO_MASK [0:NUM_WORDS-1] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hFF00_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001
  };
  localparam logic [DATA_W-1:0] WORD_RSVD_MASK [0:NUM_WORDS-1] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF, 32'hFFFF_0000
  };
  localparam logic WORD_AUX [0:NUM_WORDS-1] = '{
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0
  };

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned CTRL_RESET_NS    = 100;
  localparam int unsigned CTRL_RESET_CYC   = (CTRL_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SYNC_STAGES      = 2;
  localparam int unsigned CNT_W            = 8;

endpackage

/* rfa_field_cell.sv */
`timescale 1ns/1ps
module rfa_field_cell #(
  parameter rfa_pkg::rfa_attr_t ATTR      = rfa_pkg::ATTR_RSVD,
  parameter logic [31:0]        RESET_VAL = 32'h0000_0000,
  parameter logic [31:0]        RO_MASK   = 32'h0000_0000,
  parameter logic [31:0]        RSVD_MASK = 32'h0000_0000,
  parameter logic               AUX       = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wr_stb,
  input  wire logic [31:0] wr_data,
  input  wire logic [31:0] hw_val,
  input  wire logic [31:0] hw_set,
  input  wire logic        init_load,
  input  wire logic [31:0] init_val,
  input  wire logic        ctrl_rst,
  input  wire logic        hot_rst,
  input  wire logic        warm_rst,
  input  wire logic        cold_rst,
  input  wire logic        aux_en,
  output logic      [31:0] q,
  output logic             discard
);

  logic [31:0] q_ff;
  logic [31:0] nxt_q;
  logic        locked_ff;
  logic [31:0] wmask;
  logic        keep;
  logic        plain_rst;

  assign wmask     = wr_stb ? (wr_data & ~RO_MASK) : 32'h0000_0000;
  assign keep      = AUX & aux_en;                                                   // [R9]
  assign plain_rst = ctrl_rst | hot_rst | warm_rst | cold_rst;

  // ************************************************************
  // Next value by attribute
  // ************************************************************
  always_comb begin
    nxt_q = q_ff;
    case (ATTR)
      rfa_pkg::ATTR_HARDWARE_INITIALISED_FIELD: if (init_load) nxt_q = init_val;                         // [R1]
      rfa_pkg::ATTR_RO:     nxt_q = hw_val;                                          // [R2]
      rfa_pkg::ATTR_WO:     if (wr_stb && !locked_ff) nxt_q = wr_data;               // [R3]
      rfa_pkg::ATTR_RW: begin
        if (plain_rst) nxt_q = RESET_VAL;
        else if (wr_stb) nxt_q = wr_data;                                            // [R4]
        nxt_q = (nxt_q & ~RO_MASK) | (hw_val & RO_MASK);                             // [R4]
      end
      rfa_pkg::ATTR_W1C: begin
        if (plain_rst) nxt_q = RESET_VAL;
        else nxt_q = (q_ff & ~wmask) | hw_set;                                       // [R5]
      end
      // Hardware clear loses to a software set in the same cycle
      rfa_pkg::ATTR_W1S: begin
        if (plain_rst) nxt_q = RESET_VAL;
        else nxt_q = (q_ff & ~hw_set) | wmask;                                       // [R6]
      end
      rfa_pkg::ATTR_RWS: begin
        if (hot_rst && !keep) nxt_q = RESET_VAL;                                     // [R7]
        else if (wr_stb) nxt_q = wr_data;                                            // [R7]
      end
      rfa_pkg::ATTR_STICKY_WRITE_ONE_CLEAR_FIELD: begin
        if ((warm_rst || cold_rst) && !keep) nxt_q = RESET_VAL;                      // [R9]
        else nxt_q = (q_ff & ~wmask) | hw_set;                                       // [R8]
      end
      default:              nxt_q = 32'h0000_0000;                                   // [R10]
    endcase
    nxt_q = nxt_q & ~RSVD_MASK;                                                      // [R10]
  end

  always_ff @(posedge clk) begin
    if (!reset_n) q_ff <= RESET_VAL & ~RSVD_MASK;
    else          q_ff <= nxt_q;
  end

  // Lock survives every reset but power-up
  always_ff @(posedge clk) begin
    if (!reset_n) locked_ff <= 1'b0;
    else if (ATTR == rfa_pkg::ATTR_WO && wr_stb) locked_ff <= 1'b1;                   // [R3]
  end

  assign q       = q_ff;
  assign discard = wr_stb && (ATTR == rfa_pkg::ATTR_RO || ATTR == rfa_pkg::ATTR_HARDWARE_INITIALISED_FIELD ||
                              ATTR == rfa_pkg::ATTR_RSVD ||
                              (ATTR == rfa_pkg::ATTR_WO && locked_ff));              // [R14]

endmodule // rfa_field_cell

/* rfa_reset_seq.sv */
`timescale 1ns/1ps
module rfa_reset_seq (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      ctrl_rst,
  output logic      busy,
  output logic      init_load
);

  typedef enum {ST_SETTLE, ST_RESET, ST_LOAD, ST_IDLE} rfa_seq_t;

  localparam logic [rfa_pkg::CNT_W-1:0] RST_LAST  = rfa_pkg::CNT_W'(rfa_pkg::CTRL_RESET_CYC - 1);
  localparam logic [rfa_pkg::CNT_W-1:0] SYNC_LAST = rfa_pkg::CNT_W'(rfa_pkg::SYNC_STAGES);

  rfa_seq_t                   state_ff;
  logic [rfa_pkg::CNT_W-1:0]  cnt_ff;

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Settle first so the synchronised straps are valid before loading
  always_ff @(posedge clk) begin
    if (!reset_n) state_ff <= ST_SETTLE;
    else begin
      case (state_ff)
        ST_SETTLE: if (cnt_ff == SYNC_LAST) state_ff <= ST_LOAD;
        ST_IDLE:   if (start) state_ff <= ST_RESET;                                  // [R13]
        ST_RESET:  if (cnt_ff == RST_LAST) state_ff <= ST_LOAD;
        ST_LOAD:   state_ff <= ST_IDLE;
        default:   state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) cnt_ff <= '0;
    else if (state_ff == ST_SETTLE || state_ff == ST_RESET) cnt_ff <= cnt_ff + 1'b1;
    else cnt_ff <= '0;
  end

  assign ctrl_rst  = (state_ff == ST_RESET);
  assign init_load = (state_ff == ST_LOAD);                                          // [R1]
  assign busy      = (state_ff != ST_IDLE);

endmodule // rfa_reset_seq

/* rfa_register_bank.sv */
`timescale 1ns/1ps
// Summary of operation
// [R1] Hardware-initialised fields load once, reload on controller reset
// [R2] Read-only fields ignore writes, follow hardware
// [R3] Write-once fields take first write only
// [R4] Read-write fields store writes; read-only bits excepted
// [R5] Write one clears status bit; zero ignored
// [R6] Write one sets bit; zero ignored
// [R7] Sticky read-write changes only by write, hot reset
// [R8] Sticky status clears on one; hot reset ignored
// [R9] Aux-powered sticky fields survive hot, warm, cold
// [R10] Reserved bits read zero, writes have no effect
// [R11] Software treats reserved space as read-only
// [R12] Structural parameters report usable root port count
// [R13] Controller reset flag write starts controller reset
// [R14] Discarded writes still complete without error
module rfa_register_bank (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        hot_reset,
  input  wire logic                        warm_reset,
  input  wire logic                        cold_reset,
  input  wire logic                        aux_pwr_en,
  input  wire logic [7:0]                  port_count_strap,
  input  wire logic [31:0]                 rom_init_data,
  input  wire logic [31:0]                 hw_status,
  input  wire logic [31:0]                 hw_event,
  input  wire logic [31:0]                 sticky_event,
  input  wire logic [31:0]                 hw_clear,
  input  wire logic                        acc_wr_en,
  input  wire logic                        acc_rd_en,
  input  wire logic [rfa_pkg::ADDR_W-1:0]  acc_addr,
  input  wire logic [31:0]                 acc_wr_data,
  output logic      [31:0]                 acc_rd_data,
  output logic                             acc_rd_valid,
  output logic                             acc_wr_done,
  output logic                             acc_wr_discard,
  output logic                             ctrl_reset_active,
  output logic      [31:0]                 control_out,
  output logic      [31:0]                 sticky_control_out
);

  localparam int unsigned NW = rfa_pkg::NUM_WORDS;

  // ************************************************************
  // Strap synchroniser
  // ************************************************************
  logic [7:0] strap_meta_ff;
  logic [7:0] strap_sync_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      strap_meta_ff <= 8'h00;
      strap_sync_ff <= 8'h00;
    end else begin
      strap_meta_ff <= port_count_strap;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // ************************************************************
  // Controller reset sequencing
  // ************************************************************
  logic ctrl_rst;
  logic seq_busy;
  logic init_load;
  logic flag_start;

  // A new flag write while a reset is running is absorbed by it
  assign flag_start = acc_wr_en && (acc_addr == rfa_pkg::IDX_COMMAND) &&
                      acc_wr_data[rfa_pkg::CONTROLLER_RESET_FLAG];                   // [R13]

  rfa_reset_seq u_reset_seq (
    .clk       (clk),
    .reset_n   (reset_n),
    .start     (flag_start),
    .ctrl_rst  (ctrl_rst),
    .busy      (seq_busy),
    .init_load (init_load)
  );

  // ************************************************************
  // Initial value of the structural parameters
  // ************************************************************
  logic [31:0] struct_init;

  always_comb begin
    struct_init = rom_init_data;
    struct_init[rfa_pkg::PORT_COUNT_LSB +: rfa_pkg::PORT_COUNT_W] = strap_sync_ff;    // [R12]
  end

  // ************************************************************
  // Field words
  // ************************************************************
  logic [31:0] word_q   [NW];
  logic [NW-1:0] word_discard;
  logic [NW-1:0] word_sel;

  genvar gi;
  generate
    for (gi = 0; gi < NW; gi++) begin : g_word
      localparam rfa_pkg::rfa_attr_t A = rfa_pkg::WORD_ATTR[gi];
      logic [31:0] hw_val_w;
      logic [31:0] hw_set_w;

      assign word_sel[gi] = (acc_addr == rfa_pkg::ADDR_W'(gi));

      // The command word reflects the busy reset sequencer (settle, reset or load) in its flag bit
      if (gi == rfa_pkg::IDX_COMMAND) begin : g_cmd
        assign hw_val_w = {hw_status[31:1], seq_busy};                               // [R13]
      end else begin : g_plain
        assign hw_val_w = hw_status;                                                 // [R2]
      end

      if (A == rfa_pkg::ATTR_W1C) begin : g_ev
        assign hw_set_w = hw_event;                                                  // [R5]
      end else if (A == rfa_pkg::ATTR_STICKY_WRITE_ONE_CLEAR_FIELD) begin : g_sev
        assign hw_set_w = sticky_event;                                              // [R8]
      end else begin : g_clr
        assign hw_set_w = hw_clear;                                                  // [R6]
      end

      rfa_field_cell #(
        .ATTR      (A),
        .RESET_VAL (rfa_pkg::WORD_RESET[gi]),
        .RO_MASK   (rfa_pkg::WORD_RO_MASK[gi]),
        .RSVD_MASK (rfa_pkg::WORD_RSVD_MASK[gi]),
        .AUX       (rfa_pkg::WORD_AUX[gi])
      ) u_cell (
        .clk       (clk),
        .reset_n   (reset_n),
        .wr_stb    (acc_wr_en && word_sel[gi]),
        .wr_data   (acc_wr_data),
        .hw_val    (hw_val_w),
        .hw_set    (hw_set_w),
        .init_load (init_load),
        .init_val  (struct_init),
        .ctrl_rst  (ctrl_rst),
        .hot_rst   (hot_reset),
        .warm_rst  (warm_reset),
        .cold_rst  (cold_reset),
        .aux_en    (aux_pwr_en),
        .q         (word_q[gi]),
        .discard   (word_discard[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Read port
  // ************************************************************
  // Unmapped indices read zero like reserved space
  always_ff @(posedge clk) begin
    if (!reset_n) acc_rd_data <= 32'h0000_0000;
    else if (acc_rd_en && (acc_addr < rfa_pkg::ADDR_W'(NW))) acc_rd_data <= word_q[acc_addr]; // [R10]
    else if (acc_rd_en) acc_rd_data <= 32'h0000_0000;                               // [R10]
  end

  always_ff @(posedge clk) begin
    if (!reset_n) acc_rd_valid <= 1'b0;
    else          acc_rd_valid <= acc_rd_en;
  end

  // ************************************************************
  // Write completion
  // ************************************************************
  // Every write completes, whatever the field did with it
  always_ff @(posedge clk) begin
    if (!reset_n) acc_wr_done <= 1'b0;
    else          acc_wr_done <= acc_wr_en;                                          // [R14]
  end

  always_ff @(posedge clk) begin
    if (!reset_n) acc_wr_discard <= 1'b0;
    else acc_wr_discard <= acc_wr_en && ((|word_discard) || (acc_addr >= rfa_pkg::ADDR_W'(NW))); // [R14]
  end

  // ************************************************************
  // Control outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control_out        <= 32'h0000_0000;
      sticky_control_out <= 32'h0000_0000;
    end else begin
      control_out        <= word_q[rfa_pkg::IDX_CONTROL];
      sticky_control_out <= word_q[rfa_pkg::IDX_STICKY_CTRL];
    end
  end

  assign ctrl_reset_active = ctrl_rst;                                               // [R13]

endmodule // rfa_register_bank

/* rfa_register_bank_sva.sv */
`timescale 1ns/1ps
module rfa_register_bank_chk (
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic                       hot_reset,
  input wire logic                       aux_pwr_en,
  input wire logic                       acc_wr_en,
  input wire logic                       acc_rd_en,
  input wire logic [rfa_pkg::ADDR_W-1:0] acc_addr,
  input wire logic [31:0]                acc_wr_data,
  input wire logic [31:0]                acc_rd_data,
  input wire logic                       acc_rd_valid,
  input wire logic                       acc_wr_done,
  input wire logic                       acc_wr_discard,
  input wire logic                       ctrl_reset_active,
  input wire logic [31:0]                sticky_control_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****
  // Controller reset length counter
  // ****
  logic [7:0] act_cnt_ff;
  logic [7:0] nxt_act_cnt;
  assign nxt_act_cnt = ctrl_reset_active ? act_cnt_ff + 8'h01 : 8'h00;
  logic rsvd_rd;
  logic ro_wr;
  assign rsvd_rd = acc_rd_en && acc_addr >= rfa_pkg::IDX_RESERVED && acc_addr != rfa_pkg::IDX_COMMAND;
  assign ro_wr   = acc_wr_en && (acc_addr <= rfa_pkg::IDX_HW_STATUS || acc_addr >= rfa_pkg::IDX_RESERVED) &&
                   acc_addr != rfa_pkg::IDX_COMMAND;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      act_cnt_ff <= 8'h00;
    end else begin
      act_cnt_ff <= nxt_act_cnt;
    end
  end
  // ****
  // Assertions
  // ****
  sequence s_sticky_wr;
    acc_wr_en && acc_addr == rfa_pkg::IDX_STICKY_CTRL && !hot_reset;
  endsequence
  sequence s_hot_no_wr;
    hot_reset && !(acc_wr_en && acc_addr == rfa_pkg::IDX_STICKY_CTRL);
  endsequence
  AST_RD_VALID: assert property (acc_rd_en |=> acc_rd_valid)
    else $error("read not answered");
  AST_WR_DONE: assert property (acc_wr_en |=> acc_wr_done)
    else $error("write not completed");
  AST_NO_DONE: assert property (!acc_wr_en && !acc_rd_en |=> !acc_wr_done && !acc_rd_valid)
    else $error("answer without request");
  AST_RSVD_ZERO: assert property (rsvd_rd |=> acc_rd_data == 32'h0000_0000)
    else $error("reserved read not zero");
  AST_RO_DISCARD: assert property (ro_wr |=> acc_wr_done && acc_wr_discard)
    else $error("read-only write not discarded");
  AST_RW_KEEP: assert property (acc_wr_en && acc_addr inside {4'h3, 4'h5, 4'h6} |=> !acc_wr_discard)
    else $error("writable word discarded");
  AST_CTRL_LEN: assert property ($fell(ctrl_reset_active) |-> act_cnt_ff == 8'(rfa_pkg::CTRL_RESET_CYC))
    else $error("controller reset length wrong");
  AST_STICKY_WR: assert property (s_sticky_wr |-> ##2 sticky_control_out == $past(acc_wr_data, 2))
    else $error("sticky word lost write");
  AST_HOT_AUX: assert property (s_hot_no_wr and aux_pwr_en |-> ##2 $stable(sticky_control_out))
    else $error("aux sticky word changed by hot reset");
  AST_HOT_INIT: assert property (s_hot_no_wr and !aux_pwr_en |-> ##2 sticky_control_out == 32'h0000_0000)
    else $error("sticky word not initialised by hot reset");
endmodule // rfa_register_bank_chk

bind rfa_register_bank rfa_register_bank_chk i_rfa_register_bank_chk (.clk(clk), .reset_n(reset_n),
  .hot_reset(hot_reset), .aux_pwr_en(aux_pwr_en), .acc_wr_en(acc_wr_en), .acc_rd_en(acc_rd_en),
  .acc_addr(acc_addr), .acc_wr_data(acc_wr_data), .acc_rd_data(acc_rd_data), .acc_rd_valid(acc_rd_valid),
  .acc_wr_done(acc_wr_done), .acc_wr_discard(acc_wr_discard), .ctrl_reset_active(ctrl_reset_active),
  .sticky_control_out(sticky_control_out));

/* rfa_host_model.sv */
`timescale 1ns/1ps
module rfa_host_model (
  input  wire logic                       clk,
  output logic                            acc_wr_en,
  output logic                            acc_rd_en,
  output logic      [rfa_pkg::ADDR_W-1:0] acc_addr,
  output logic      [31:0]                acc_wr_data,
  input  wire logic [31:0]                acc_rd_data,
  input  wire logic                       acc_rd_valid,
  input  wire logic                       acc_wr_done,
  input  wire logic                       acc_wr_discard
);
  initial begin
    acc_wr_en   = 1'b0;
    acc_rd_en   = 1'b0;
    acc_addr    = 4'h0;
    acc_wr_data = 32'h0000_0000;
  end
  // ****
  // One transfer, answer sampled half a cycle after the taking edge
  // ****
  task automatic acc(input logic we, input logic re, input logic [rfa_pkg::ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] q, output logic [2:0] st);
    @(negedge clk);
    acc_wr_en   = we;
    acc_rd_en   = re;
    acc_addr    = a;
    acc_wr_data = d;
    @(negedge clk);
    // Caller alone decides which bits matter; reserved bits are passed on raw
    q           = acc_rd_data;
    st          = {acc_wr_done, acc_wr_discard, acc_rd_valid};
    acc_wr_en   = 1'b0;
    acc_rd_en   = 1'b0;
    // Released lines flip so a stale value never looks valid
    acc_addr    = ~acc_addr;
    acc_wr_data = ~acc_wr_data;
  endtask
endmodule // rfa_host_model

/* rfa_register_bank_tb.sv */
`timescale 1ns/1ps
module rfa_register_bank_tb;
  typedef struct {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        disc;
    logic [31:0] rdata;
  } rfa_row_t;
  logic                       clk, reset_n, hot_reset, warm_reset, cold_reset, aux_pwr_en;
  logic                       acc_wr_en, acc_rd_en, acc_rd_valid, acc_wr_done, acc_wr_discard, ctrl_reset_active;
  logic [7:0]                 port_count_strap;
  logic [31:0]                rom_init_data, hw_status, hw_event, sticky_event, hw_clear;
  logic [31:0]                acc_wr_data, acc_rd_data, control_out, sticky_control_out, q;
  logic [rfa_pkg::ADDR_W-1:0] acc_addr;
  logic [2:0]                 st;
  int                         bad_count, total_checks, n;
  rfa_row_t rows [0:10] = '{'{4'h0, 32'hFFFF_FFFF, 1'b1, 32'hA5A5_A53C}, '{4'h1, 32'hFFFF_FFFF, 1'b1, 32'h1234_5678},
    '{4'h2, 32'h0000_1111, 1'b0, 32'h0000_1111}, '{4'h2, 32'hFFFF_0000, 1'b1, 32'h0000_1111},
    '{4'h3, 32'hFFFF_FFFF, 1'b0, 32'h12FF_FFFF}, '{4'h3, 32'h0000_0000, 1'b0, 32'h1200_0000},
    '{4'h5, 32'h0000_00F0, 1'b0, 32'h0000_00F0}, '{4'h5, 32'h0000_000F, 1'b0, 32'h0000_00FF},
    '{4'h6, 32'h8765_4321, 1'b0, 32'h8765_4321}, '{4'h8, 32'hFFFF_FFFF, 1'b1, 32'h0000_0000},
    '{4'hF, 32'hFFFF_FFFF, 1'b1, 32'h0000_0000}};

  rfa_register_bank i_rfa_register_bank (.clk(clk), .reset_n(reset_n), .hot_reset(hot_reset),
    .warm_reset(warm_reset), .cold_reset(cold_reset), .aux_pwr_en(aux_pwr_en), .port_count_strap(port_count_strap),
    .rom_init_data(rom_init_data), .hw_status(hw_status), .hw_event(hw_event), .sticky_event(sticky_event),
    .hw_clear(hw_clear), .acc_wr_en(acc_wr_en), .acc_rd_en(acc_rd_en), .acc_addr(acc_addr),
    .acc_wr_data(acc_wr_data), .acc_rd_data(acc_rd_data), .acc_rd_valid(acc_rd_valid), .acc_wr_done(acc_wr_done),
    .acc_wr_discard(acc_wr_discard), .ctrl_reset_active(ctrl_reset_active), .control_out(control_out),
    .sticky_control_out(sticky_control_out));
  rfa_host_model i_rfa_host_model (.clk(clk), .acc_wr_en(acc_wr_en), .acc_rd_en(acc_rd_en), .acc_addr(acc_addr),
    .acc_wr_data(acc_wr_data), .acc_rd_data(acc_rd_data), .acc_rd_valid(acc_rd_valid), .acc_wr_done(acc_wr_done),
    .acc_wr_discard(acc_wr_discard));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    i_rfa_host_model.acc(1'b0, 1'b1, a, 32'h0000_0000, q, st);
    chk(32'(st), 32'h0000_0001);
    chk(q, exp);
  endtask
  task automatic wr_rd(input logic [3:0] a, input logic [31:0] d, input logic disc, input logic [31:0] exp);
    i_rfa_host_model.acc(1'b1, 1'b0, a, d, q, st);
    chk(32'(st), {29'h0, 1'b1, disc, 1'b0});
    rd(a, exp);
  endtask
  // Hot, warm and cold pulses last one cycle; aux level is left as set
  task automatic pulse(input logic h, input logic w, input logic c, input logic x);
    @(negedge clk);
    {hot_reset, warm_reset, cold_reset, aux_pwr_en} = {h, w, c, x};
    @(negedge clk);
    {hot_reset, warm_reset, cold_reset} = 3'b000;
  endtask
  task automatic conclude;
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {reset_n, hot_reset, warm_reset, cold_reset, aux_pwr_en} = 5'b00000;
    port_count_strap = 8'h3C;
    rom_init_data    = 32'hA5A5_A5A5;
    hw_status        = 32'h1234_5678;
    {hw_event, sticky_event, hw_clear} = {3{32'h0000_0000}};
    bad_count        = 0;
    total_checks     = 0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    rd(4'h2, 32'h0000_0000);
    foreach (rows[k]) begin
      wr_rd(rows[k].addr, rows[k].wdata, rows[k].disc, rows[k].rdata);
    end
    i_rfa_host_model.acc(1'b1, 1'b1, 4'h3, 32'h00AB_CDEF, q, st);
    chk(32'(st), 32'h0000_0005);
    chk(q, 32'h1200_0000);
    // Control output lags the field by one register stage
    @(negedge clk);
    chk(control_out, 32'h12AB_CDEF);
    hw_event = 32'h0000_0101;
    @(negedge clk);
    hw_event = 32'h0000_0000;
    wr_rd(4'h4, 32'h0000_0000, 1'b0, 32'h0000_0101);
    wr_rd(4'h4, 32'h0000_0001, 1'b0, 32'h0000_0100);
    hw_clear = 32'h0000_0011;
    @(negedge clk);
    hw_clear = 32'h0000_0000;
    rd(4'h5, 32'h0000_00EE);
    sticky_event = 32'h0000_0003;
    @(negedge clk);
    sticky_event = 32'h0000_0000;
    wr_rd(4'h7, 32'h0000_0001, 1'b0, 32'h0000_0002);
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    rd(4'h7, 32'h0000_0002);
    rd(4'h6, 32'h8765_4321);
    pulse(1'b0, 1'b1, 1'b1, 1'b1);
    rd(4'h7, 32'h0000_0002);
    rd(4'h6, 32'h8765_4321);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    rd(4'h6, 32'h0000_0000);
    rd(4'h7, 32'h0000_0002);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    rd(4'h7, 32'h0000_0000);
    wr_rd(4'h3, 32'h0000_00FF, 1'b0, 32'h1200_00FF);
    // New init source only shows after a controller reset
    rom_init_data = 32'h5A5A_5A5A;
    rd(4'h0, 32'hA5A5_A53C);
    i_rfa_host_model.acc(1'b1, 1'b0, 4'h9, 32'h0000_0001, q, st);
    n = 0;
    repeat (200) begin
      if (ctrl_reset_active === 1'b1) n++;
      @(negedge clk);
    end
    chk(32'(n), 32'(rfa_pkg::CTRL_RESET_CYC));
    rd(4'h3, 32'h1200_0000);
    rd(4'h0, 32'h5A5A_5A3C);
    wr_rd(4'h2, 32'h0000_0000, 1'b1, 32'h0000_1111);
    // Power-up reset in mid-run unlocks the write-once word
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(control_out, 32'h0000_0000);
    reset_n = 1'b1;
    rd(4'h9, 32'h0000_0001);
    rd(4'h2, 32'h0000_0000);
    wr_rd(4'h2, 32'h0000_2222, 1'b0, 32'h0000_2222);
    rd(4'h0, 32'h5A5A_5A3C);
    conclude();
  end
endmodule // rfa_register_bank_tb
